// [core/scs_pkg.sv]
// Shared constants and types of the two-wire control/status block
package scs_pkg;

	// Control/status register address and reset value
	localparam logic [7:0] CTL_ADDR = 8'hc0;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// Bit positions inside the control/status register
	localparam int POS_MASTER = 7;
	localparam int POS_TX = 6;
	localparam int POS_BEGIN = 5;
	localparam int POS_END = 4;
	localparam int POS_ACK_REQUEST = 3;
	localparam int POS_ARB = 2;
	localparam int POS_ACK = 1;
	localparam int POS_IRQ = 0;

	// Frame bit counter landmarks
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] FRAME_END = 4'h9;

	// Half period of the generated serial clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int HALF_BIT_NS = 5000;
	localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int HALF_MIN_CYC = 8;
	localparam int HALF_MAX_CYC = 255;

	// Control/status fields, bit 7 first
	typedef struct packed {
		logic master;
		logic transmit_indicator;
		logic begin_condition_flag;
		logic end_condition_flag;
		logic ack_request;
		logic arbitration_lost_flag;
		logic ack;
		logic interrupt_pending_flag;
	} scs_ctl_t;

	// Special-function register access, byte or single bit
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
		logic bit_wr;
		logic [2:0] bit_sel;
		logic bit_val;
	} scs_sfr_req_t;

	// Line levels and condition toggles leaving the link domain
	typedef struct packed {
		logic scl;
		logic sda;
		logic start_t;
		logic stop_t;
	} scs_line_t;

	// Master sequencer states
	typedef enum logic [6:0] {
		M_IDLE = 7'h01,
		M_START = 7'h02,
		M_WAIT = 7'h04,
		M_LOW = 7'h08,
		M_HIGH = 7'h10,
		M_PLOW = 7'h20,
		M_PHIGH = 7'h40
	} scs_mst_t;

endpackage

// [core/scs_line_mon.sv]
// Link-clock monitor of the bus lines: START and STOP detection
`timescale 1ns/10ps
module scs_line_mon (
	input wire logic link_clk,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_i,
	output scs_pkg::scs_line_t line
);

	typedef struct packed {
		logic rst1;
		logic rst2;
		logic scl1;
		logic scl2;
		logic scl3;
		logic sda1;
		logic sda2;
		logic sda3;
		scs_pkg::scs_line_t line;
	} scs_mon_st_t;

	scs_mon_st_t s;
	scs_mon_st_t next_s;

	// Synchronise pins and reset, detect conditions while SCL is high
	always_comb begin
		next_s = s;
		next_s.rst1 = srst;
		next_s.rst2 = s.rst1;
		next_s.scl1 = scl_i;
		next_s.scl2 = s.scl1;
		next_s.scl3 = s.scl2;
		next_s.sda1 = sda_i;
		next_s.sda2 = s.sda1;
		next_s.sda3 = s.sda2;
		next_s.line.scl = s.scl2;
		next_s.line.sda = s.sda2;
		// Falling SDA under high SCL
		if (s.scl2 && s.scl3 && s.sda3 && !s.sda2) begin
			next_s.line.start_t = ~s.line.start_t;
		end
		// Rising SDA under high SCL
		if (s.scl2 && s.scl3 && !s.sda3 && s.sda2) begin
			next_s.line.stop_t = ~s.line.stop_t;
		end
		if (s.rst2) begin
			next_s.scl3 = 1'b1;
			next_s.sda3 = 1'b1;
			next_s.line = '{scl: 1'b1, sda: 1'b1, start_t: 1'b0,
				stop_t: 1'b0};
		end
	end

	always_ff @(posedge link_clk) begin
		s <= next_s;
	end

	assign line = s.line;

endmodule

// [core/scs_core.sv]
// Two-wire bus control/status register and its bus sequencing
`timescale 1ns/10ps
module scs_core #(
	parameter int HALF_CYC = scs_pkg::HALF_BIT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input scs_pkg::scs_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic data_wr,
	input wire logic [7:0] data_in,
	output logic [7:0] rx_byte,
	input wire logic hw_ack_en,
	input wire logic slave_en
);

	// Half period must outlast the line synchroniser delay
	if (HALF_CYC < scs_pkg::HALF_MIN_CYC || HALF_CYC > scs_pkg::HALF_MAX_CYC)
	begin : g_chk
		$error("HALF_CYC out of range");
	end

	localparam logic [7:0] HALF = 8'(HALF_CYC);

	typedef struct packed {
		scs_pkg::scs_line_t sy1;
		scs_pkg::scs_line_t sy2;
		scs_pkg::scs_line_t sy3;
		scs_pkg::scs_ctl_t ctl;
		scs_pkg::scs_mst_t mst;
		logic [7:0] cnt;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] txb;
		logic [7:0] rxb;
		logic [7:0] rdata;
		logic sda_rel;
		logic start_req;
		logic own_start;
		logic own_stop;
		logic busy;
		logic addr_phase;
		logic slave_act;
		logic slave_inh;
		logic wr_flag;
		logic ack_wr;
		logic armed;
		logic pstop;
	} scs_core_st_t;

	scs_core_st_t s;
	scs_core_st_t next_s;
	scs_pkg::scs_line_t line;

	// Link-side condition detector
	scs_line_mon u_mon (
		.link_clk(link_clk),
		.srst(srst),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.line(line)
	);

	// Register access, bus events and master sequencing
	always_comb begin
		logic scl_s;
		logic sda_s;
		logic rise;
		logic fall;
		logic start_ev;
		logic stop_ev;
		logic part;
		logic hit;
		logic [7:0] wen;
		logic [7:0] wval;
		logic ack_eff;
		logic lose;
		scl_s = s.sy2.scl;
		sda_s = s.sy2.sda;
		rise = scl_s & ~s.sy3.scl;
		fall = ~scl_s & s.sy3.scl;
		start_ev = s.sy2.start_t ^ s.sy3.start_t;
		stop_ev = s.sy2.stop_t ^ s.sy3.stop_t;
		part = s.ctl.master | s.slave_act |
			(s.addr_phase & slave_en & ~s.slave_inh);
		hit = (sfr_req.addr == scs_pkg::CTL_ADDR);
		wen = 8'h00;
		if (hit && sfr_req.wr) begin
			wen = 8'hff;
		end else if (hit && sfr_req.bit_wr) begin
			wen = 8'h01 << sfr_req.bit_sel;
		end
		wval = sfr_req.wr ? sfr_req.wdata : {8{sfr_req.bit_val}};
		ack_eff = wen[scs_pkg::POS_ACK] ? wval[scs_pkg::POS_ACK] :
			((s.ack_wr | ~s.ctl.ack_request) & s.ctl.ack);
		lose = 1'b0;

		next_s = s;
		next_s.sy1 = line;
		next_s.sy2 = s.sy1;
		next_s.sy3 = s.sy2;
		next_s.rdata = hit ? s.ctl : 8'h00;

		// Data register write, remembered for the next frame
		if (data_wr) begin
			next_s.txb = data_in;
			next_s.wr_flag = 1'b1;
		end

		// Software writes, applied before hardware so a hardware update wins
		if (wen[scs_pkg::POS_BEGIN]) begin
			next_s.ctl.begin_condition_flag = wval[scs_pkg::POS_BEGIN];
			if (wval[scs_pkg::POS_BEGIN]) begin
				next_s.start_req = 1'b1;
			end
		end
		if (wen[scs_pkg::POS_END]) begin
			next_s.ctl.end_condition_flag = wval[scs_pkg::POS_END];
		end
		if (wen[scs_pkg::POS_ACK]) begin
			next_s.ctl.ack = wval[scs_pkg::POS_ACK];
			next_s.ack_wr = 1'b1;
		end
		if (wen[scs_pkg::POS_IRQ]) begin
			next_s.ctl.interrupt_pending_flag = wval[scs_pkg::POS_IRQ];
		end
		if (wen[scs_pkg::POS_IRQ] && !wval[scs_pkg::POS_IRQ] &&
			s.ctl.interrupt_pending_flag) begin
			next_s.ctl.arbitration_lost_flag = 1'b0;
			if (s.ctl.ack_request && !s.ack_wr && !wen[scs_pkg::POS_ACK]) begin
				next_s.ctl.ack = 1'b0;
			end
			// Receiver drives its acknowledge once released
			if (part && !s.ctl.transmit_indicator &&
				s.bitcnt == scs_pkg::ACK_SLOT) begin
				next_s.sda_rel = ~ack_eff;
				if (s.addr_phase && !s.ctl.master) begin
					next_s.addr_phase = 1'b0;
					next_s.slave_act = ack_eff;
					next_s.slave_inh = ~ack_eff;
				end
			end
		end

		// Frame begin: direction chosen by a data write since last frame
		if (s.armed && !s.ctl.interrupt_pending_flag) begin
			next_s.armed = 1'b0;
			next_s.ctl.transmit_indicator = s.wr_flag;
			next_s.wr_flag = 1'b0;
			next_s.shreg = s.txb;
			next_s.sda_rel = s.wr_flag ? s.txb[7] : 1'b1;
		end

		// Rising SCL: sample data, acknowledge and arbitration
		if (rise && part) begin
			next_s.bitcnt = s.bitcnt + 4'h1;
			if (s.bitcnt < scs_pkg::ACK_SLOT) begin
				next_s.shreg = {s.shreg[6:0], sda_s};
				if (s.ctl.transmit_indicator && s.sda_rel && !sda_s) begin
					lose = 1'b1;
				end
			end else if (s.ctl.transmit_indicator) begin
				next_s.ctl.ack = ~sda_s;
			end
		end

		// Falling SCL: byte end, acknowledge end, next data bit
		if (fall && part) begin
			if (s.bitcnt == scs_pkg::ACK_SLOT) begin
				next_s.rxb = s.shreg;
				next_s.sda_rel = 1'b1;
				if (!s.ctl.transmit_indicator) begin
					next_s.ctl.interrupt_pending_flag = 1'b1;
					if (!hw_ack_en) begin
						next_s.ctl.ack_request = 1'b1;
						next_s.ack_wr = 1'b0;
					end
					if (s.addr_phase && !s.ctl.master) begin
						next_s.ctl.begin_condition_flag = 1'b1;
					end
				end
			end else if (s.bitcnt == scs_pkg::FRAME_END) begin
				next_s.ctl.ack_request = 1'b0;
				next_s.bitcnt = 4'h0;
				next_s.armed = 1'b1;
				next_s.sda_rel = 1'b1;
				if (s.ctl.transmit_indicator) begin
					next_s.ctl.interrupt_pending_flag = 1'b1;
				end
			end else if (s.ctl.transmit_indicator) begin
				next_s.sda_rel = s.shreg[7];
			end
		end

		// START seen on the bus
		if (start_ev) begin
			next_s.busy = 1'b1;
			if (s.own_start) begin
				next_s.own_start = 1'b0;
			end else begin
				next_s.ctl.transmit_indicator = 1'b0;
				next_s.bitcnt = 4'h0;
				next_s.addr_phase = 1'b1;
				next_s.slave_act = 1'b0;
				next_s.slave_inh = 1'b0;
				next_s.armed = 1'b0;
				next_s.sda_rel = 1'b1;
				if (s.ctl.master && !s.ctl.begin_condition_flag) begin
					lose = 1'b1;
				end
			end
		end

		// STOP seen on the bus
		if (stop_ev) begin
			next_s.busy = 1'b0;
			next_s.addr_phase = 1'b0;
			if (s.own_stop) begin
				next_s.own_stop = 1'b0;
			end else if (s.slave_act || s.ctl.master) begin
				next_s.ctl.end_condition_flag = 1'b1;
				next_s.ctl.interrupt_pending_flag = 1'b1;
				next_s.slave_act = 1'b0;
				lose = s.ctl.master;
			end
		end

		// Master sequencer
		case (s.mst)
			scs_pkg::M_IDLE: begin
				if (s.start_req && !s.busy) begin
					next_s.mst = scs_pkg::M_START;
					next_s.cnt = HALF;
					next_s.own_start = 1'b1;
				end
			end
			scs_pkg::M_START: begin
				if (!scl_s) begin
					lose = 1'b1;
				end else if (s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else begin
					next_s.mst = scs_pkg::M_WAIT;
					next_s.ctl.master = 1'b1;
					next_s.ctl.transmit_indicator = 1'b1;
					next_s.ctl.interrupt_pending_flag = 1'b1;
					next_s.start_req = 1'b0;
					next_s.armed = 1'b1;
					next_s.bitcnt = 4'h0;
					next_s.sda_rel = 1'b0;
				end
			end
			scs_pkg::M_WAIT: begin
				// Proceed only after the fall has been processed
				if (!s.ctl.interrupt_pending_flag && !s.armed && !scl_s &&
					!s.sy3.scl) begin
					next_s.cnt = HALF;
					if (s.bitcnt == 4'h0 && s.ctl.end_condition_flag) begin
						next_s.mst = scs_pkg::M_PLOW;
						next_s.pstop = 1'b1;
					end else if (s.bitcnt == 4'h0 && s.start_req) begin
						next_s.mst = scs_pkg::M_PLOW;
						next_s.pstop = 1'b0;
					end else begin
						next_s.mst = scs_pkg::M_LOW;
					end
				end
			end
			scs_pkg::M_LOW: begin
				next_s.cnt = s.cnt - 8'h01;
				if (s.cnt == 8'h00) begin
					next_s.mst = scs_pkg::M_HIGH;
					next_s.cnt = HALF;
				end
			end
			scs_pkg::M_HIGH: begin
				if (scl_s) begin
					next_s.cnt = s.cnt - 8'h01;
					if (s.cnt == 8'h00) begin
						next_s.mst = scs_pkg::M_WAIT;
					end
				end
			end
			scs_pkg::M_PLOW: begin
				next_s.cnt = s.cnt - 8'h01;
				if (s.cnt == 8'h00) begin
					next_s.mst = scs_pkg::M_PHIGH;
					next_s.cnt = HALF;
				end
			end
			scs_pkg::M_PHIGH: begin
				if (!scl_s && s.cnt != HALF) begin
					lose = 1'b1;
				end else if (scl_s && s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else if (scl_s && s.pstop) begin
					next_s.mst = scs_pkg::M_IDLE;
					next_s.own_stop = 1'b1;
					next_s.ctl.master = 1'b0;
					next_s.ctl.end_condition_flag = 1'b0;
					next_s.pstop = 1'b0;
				end else if (scl_s) begin
					next_s.mst = scs_pkg::M_START;
					next_s.cnt = HALF;
					next_s.own_start = 1'b1;
				end
			end
			default: begin
				next_s.mst = scs_pkg::M_IDLE;
			end
		endcase

		// Lost arbitration drops to slave and interrupts
		if (lose) begin
			next_s.ctl.arbitration_lost_flag = 1'b1;
			next_s.ctl.master = 1'b0;
			next_s.ctl.transmit_indicator = 1'b0;
			next_s.ctl.interrupt_pending_flag = 1'b1;
			next_s.mst = scs_pkg::M_IDLE;
			next_s.sda_rel = 1'b1;
			next_s.pstop = 1'b0;
			next_s.armed = 1'b0;
			next_s.own_start = 1'b0;
		end

		if (srst) begin
			next_s = '0;
			next_s.ctl = scs_pkg::CTL_RESET;
			next_s.mst = scs_pkg::M_IDLE;
			next_s.sda_rel = 1'b1;
			next_s.sy1 = '{scl: 1'b1, sda: 1'b1, start_t: 1'b0, stop_t: 1'b0};
			next_s.sy2 = next_s.sy1;
			next_s.sy3 = next_s.sy1;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	// Line drivers: SCL held low, once low, while the interrupt flag or a frame start is pending
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = (s.mst == scs_pkg::M_WAIT) | (s.mst == scs_pkg::M_LOW) |
		(s.mst == scs_pkg::M_PLOW) |
		((s.ctl.interrupt_pending_flag | s.armed) & ~s.sy3.scl);
	assign sda_oe = (s.mst == scs_pkg::M_START) |
		(((s.mst == scs_pkg::M_PLOW) | (s.mst == scs_pkg::M_PHIGH)) ?
		s.pstop : ~s.sda_rel);
	assign sfr_rdata = s.rdata;
	assign rx_byte = s.rxb;

endmodule

// [verif/scs_core_assertions.sv]
// Port checker for the control/status block
`timescale 1ns/10ps
module scs_core_assertions #(
	parameter int HALF_CYC = scs_pkg::HALF_BIT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input scs_pkg::scs_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata
);
	logic c0_wr;
	logic sw_wr;
	logic idle;
	logic [7:0] stall_cnt;

	// Register writes and a quiet bus
	assign c0_wr = sfr_req.addr == scs_pkg::CTL_ADDR && sfr_req.wr;
	assign sw_wr = c0_wr || sfr_req.bit_wr;
	assign idle = scl_i && sda_i && !scl_oe && !sda_oe;

	// Cycles of SCL held low with no software write
	always_ff @(posedge clk) begin
		if (srst || !scl_oe || sw_wr)
			stall_cnt <= 8'h00;
		else if (stall_cnt != 8'hff)
			stall_cnt <= stall_cnt + 8'h01;
	end

	a_reset_state: assert property (@(posedge clk)
		srst |=> sfr_rdata == 8'h00 && !scl_oe && !sda_oe)
		else $error("outputs not cleared by reset");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
		sfr_req.addr != scs_pkg::CTL_ADDR |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_write_readback: assert property (@(posedge clk) disable iff (srst)
		c0_wr && idle ##1 sfr_req.addr == scs_pkg::CTL_ADDR && !sw_wr
		|=> (sfr_rdata & 8'ha3) == ($past(sfr_req.wdata, 2) & 8'h23))
		else $error("register readback wrong");
	a_begin_starts: assert property (@(posedge clk) disable iff (srst)
		c0_wr && sfr_req.wdata[5] && idle |-> ##[1:8] sda_oe)
		else $error("no start after begin write");
	a_zero_no_start: assert property (@(posedge clk) disable iff (srst)
		c0_wr && !sfr_req.wdata[5] && idle |=> !sda_oe [*4])
		else $error("start without begin write");
	a_stall_holds: assert property (@(posedge clk) disable iff (srst)
		int'(stall_cnt) > 2 * HALF_CYC + 4 && !sw_wr |=> scl_oe)
		else $error("stalled clock released without software");
	a_start_stalls: assert property (@(posedge clk) disable iff (srst)
		$rose(sda_oe) && scl_i && !scl_oe |-> ##[1:40] scl_oe)
		else $error("no stall after generated start");
	a_drive_low_only: assert property (@(posedge clk) disable iff (srst)
		scl_o == 1'b0 && sda_o == 1'b0)
		else $error("line driven high");
endmodule

bind scs_core scs_core_assertions #(.HALF_CYC(HALF_CYC)) chk_u (
	.clk(clk), .srst(srst), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata)
);

// [verif/scs_bus_slave.sv]
// Behavioural bus slave: acks, stretches SCL, sends bytes
`timescale 1ns/10ps
module scs_bus_slave (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	input wire logic stretch,
	input wire logic [7:0] tx_byte,
	output logic sda_pull,
	output logic scl_pull
);
	int n;
	logic [7:0] sh;
	logic rd;
	logic first;

	// Slow answer: hold SCL low on command
	assign scl_pull = stretch;

	initial begin
		n = 0;
		sh = 8'h00;
		rd = 1'b0;
		first = 1'b1;
		sda_pull = 1'b0;
	end

	// START or STOP restarts the frame
	always @(sda) begin
		if (scl) begin
			n = 0;
			first = 1'b1;
			rd = 1'b0;
		end
	end

	// Sample on SCL rise; a NACK ends sending
	always @(posedge scl) begin
		if (n < 8)
			sh = {sh[6:0], sda};
		else if (rd && !first && sda)
			rd = 1'b0;
		n = n + 1;
	end

	// Drive on SCL fall: ack slot, then read data
	always @(negedge scl) begin
		if (n == 8) begin
			if (first)
				rd = sh[0];
			sda_pull = ack_en && !(rd && !first);
		end else begin
			if (n == 9) begin
				n = 0;
				first = 1'b0;
			end
			sda_pull = rd && !first && !tx_byte[7 - n];
		end
	end
endmodule

// [verif/scs_core_test.sv]
// Self-checking bench for the control/status block
`timescale 1ns/10ps
module scs_core_test;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	scs_pkg::scs_sfr_req_t req = '0;
	logic data_wr = 1'b0;
	logic [7:0] data_in = 8'h00;
	logic ack_en = 1'b1;
	logic stretch = 1'b0;
	logic hw_ack = 1'b0;
	logic m_scl = 1'b0;
	logic m_sda = 1'b0;
	logic scl_o, scl_oe, sda_o, sda_oe, sl_sda, sl_scl;
	logic [7:0] rdata;
	logic [7:0] rx_byte;
	wire scl_w;
	wire sda_w;
	int n_fail = 0;
	int compares = 0;

	// Wired-AND lines with pull-ups
	assign scl_w = (scl_oe ? scl_o : 1'b1) & !sl_scl & !m_scl;
	assign sda_w = (sda_oe ? sda_o : 1'b1) & !sl_sda & !m_sda;

	// System clock and unrelated link clock
	always #50 clk = ~clk;
	always #15 link_clk = ~link_clk;

	scs_core #(.HALF_CYC(8)) dut_u (
		.clk(clk), .srst(srst), .link_clk(link_clk),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.sfr_req(req), .sfr_rdata(rdata), .data_wr(data_wr),
		.data_in(data_in), .rx_byte(rx_byte), .hw_ack_en(hw_ack),
		.slave_en(1'b1)
	);

	scs_bus_slave sl_u (
		.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .stretch(stretch),
		.tx_byte(8'h3c), .sda_pull(sl_sda), .scl_pull(sl_scl)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] v);
		@(negedge clk);
		req.wr = 1'b1;
		req.wdata = v;
		@(negedge clk);
		req.wr = 1'b0;
	endtask

	task automatic bw(input logic [2:0] s, input logic v);
		@(negedge clk);
		req.bit_wr = 1'b1;
		req.bit_sel = s;
		req.bit_val = v;
		@(negedge clk);
		req.bit_wr = 1'b0;
	endtask

	task automatic load(input logic [7:0] v);
		@(negedge clk);
		data_wr = 1'b1;
		data_in = v;
		@(negedge clk);
		data_wr = 1'b0;
	endtask

	// Poll the register until bit b reads v, bounded
	task automatic wait_bit(input int b, input logic v, output logic [7:0] got);
		got = rdata;
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk);
			got = rdata;
			if (got[b] === v)
				break;
		end
	endtask

	// Wait out a STOP, then sample register and lines
	task automatic wait_stop(output logic [7:0] got);
		wait_bit(7, 1'b0, got);
		repeat (20) @(negedge clk);
		got = rdata;
		chk({6'h00, scl_w, sda_w}, 8'h03);
	endtask

	task automatic t_reset();
		@(negedge clk);
		chk(rdata, 8'h00);
		req.addr = 8'hc2;
		wr(8'hff);
		chk(rdata, 8'h00);
		req.addr = scs_pkg::CTL_ADDR;
		@(negedge clk);
		chk(rdata, 8'h00);
		wr(8'hce);
		@(negedge clk);
		chk(rdata, 8'h02);
		wr(8'h01);
		@(negedge clk);
		chk(rdata, 8'h01);
		bw(3'h0, 1'b0);
		@(negedge clk);
		chk(rdata, 8'h00);
	endtask

	task automatic t_mwrite();
		logic [7:0] v;
		wr(8'h20);
		wait_bit(0, 1'b1, v);
		chk(v, 8'he1);
		repeat (40) @(negedge clk);
		chk({7'h00, scl_w}, 8'h00);
		load(8'ha4);
		wr(8'h00);
		stretch = 1'b1;
		repeat (30) @(negedge clk);
		stretch = 1'b0;
		wait_bit(0, 1'b1, v);
		chk(v, 8'hc3);
		chk(rx_byte, 8'ha4);
		ack_en = 1'b0;
		load(8'h5a);
		wr(8'h00);
		wait_bit(0, 1'b1, v);
		chk(v, 8'hc1);
		ack_en = 1'b1;
		wr(8'h10);
		wait_stop(v);
		chk(v & 8'hb1, 8'h00);
	endtask

	task automatic t_mread();
		logic [7:0] v;
		wr(8'h20);
		wait_bit(0, 1'b1, v);
		chk(v, 8'he1);
		load(8'ha5);
		wr(8'h00);
		wait_bit(0, 1'b1, v);
		chk(v, 8'hc3);
		bw(3'h0, 1'b0);
		wait_bit(0, 1'b1, v);
		chk(v & 8'hfd, 8'h89);
		chk(rx_byte, 8'h3c);
		bw(3'h4, 1'b1);
		bw(3'h0, 1'b0);
		wait_stop(v);
		chk(v & 8'hb9, 8'h00);
		chk({7'h00, sl_u.rd}, 8'h00);
	endtask

	// Master read with hardware acknowledge: no ack request
	task automatic t_hwack();
		logic [7:0] v;
		wr(8'h20);
		wait_bit(0, 1'b1, v);
		chk(v, 8'he1);
		load(8'ha5);
		wr(8'h00);
		wait_bit(0, 1'b1, v);
		chk(v, 8'hc3);
		hw_ack = 1'b1;
		wr(8'h02);
		wait_bit(0, 1'b1, v);
		chk(v & 8'hfd, 8'h81);
		chk(rx_byte, 8'h3c);
		wr(8'h10);
		wait_stop(v);
		chk(v & 8'hb9, 8'h00);
		hw_ack = 1'b0;
	endtask

	// Another master addresses the block, which acks and sees STOP
	task automatic t_slave();
		logic [7:0] a;
		a = 8'h42;
		ack_en = 1'b0;
		m_sda = 1'b1;
		repeat (20) @(negedge clk);
		m_scl = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			repeat (10) @(negedge clk);
			m_sda = !a[i];
			repeat (10) @(negedge clk);
			m_scl = 1'b0;
			repeat (20) @(negedge clk);
			m_scl = 1'b1;
		end
		repeat (10) @(negedge clk);
		m_sda = 1'b0;
		repeat (20) @(negedge clk);
		chk(rdata, 8'h29);
		chk(rx_byte, 8'h42);
		chk({7'h00, scl_oe}, 8'h01);
		wr(8'h02);
		repeat (5) @(negedge clk);
		m_scl = 1'b0;
		repeat (20) @(negedge clk);
		chk({6'h00, scl_w, sda_w}, 8'h02);
		m_scl = 1'b1;
		repeat (20) @(negedge clk);
		m_sda = 1'b1;
		repeat (10) @(negedge clk);
		m_scl = 1'b0;
		repeat (20) @(negedge clk);
		m_sda = 1'b0;
		repeat (20) @(negedge clk);
		chk(rdata, 8'h13);
		wr(8'h00);
		ack_en = 1'b1;
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cut a hang short
	initial begin
		#5000000;
		n_fail++;
		test_done();
	end

	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		srst = 1'b0;
		t_reset();
		t_mwrite();
		t_mread();
		t_hwack();
		t_slave();
		test_done();
	end
endmodule
